// ### logic/dctg_ctrl_end.sv
// Controller end: command spacing guard, refresh scheduler and power sequencing
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - At most four activates per window
// - Column commands two cycles apart
// - Autoprecharge write waits recovery plus precharge
// - Nanosecond minimums round up to cycles
// - Write data to read gap, two minimum
// - Read to precharge gap per bank
// - Self-refresh exit delays non-read commands
// - Self-refresh exit waits 200 before read
// - Power-down exit delays non-read commands
// - A12 picks fast or slow exit
// - Clock enable levels held three cycles
// - New termination setting after bounded delay
// - Calibration pattern starts within bound
// - Refresh cycle time before activate, refresh
// - Average refresh interval kept bounded
// - Termination on two cycles after high
// - Termination off two and half cycles
// - Termination level settled before power-down
// - Termination changes wait after power-down exit
// - Clock kept running after enable drops
// - Counts are whole input clock edges
module dctg_ctrl_end
	import dctg_pkg::*;
#(
	parameter int NUM_BANKS = 8,
	parameter int WR_DATA_CYC = 4,
	parameter int REF_MARGIN = 64
)
(
	input wire logic srst,
	dctg_link_if.ctrl link,
	input wire logic req_valid,
	input wire dctg_cmd_t req_cmd,
	input wire logic [BANK_W-1:0] req_bank,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic req_autopre,
	output logic req_ready,
	input wire logic odt_req,
	input wire logic [WRP_W-1:0] wr_recovery,
	input wire logic [AL_W-1:0] additive_latency,
	input wire logic slow_exit,
	output logic refresh_urgent,
	output logic clk_stop_ok,
	output var dctg_pwr_t pwr_state
);
	// --------------------------------------------------------------
	// Parameter checks
	// --------------------------------------------------------------
	if (NUM_BANKS < 1 || NUM_BANKS > (1 << BANK_W))
		$error("NUM_BANKS out of range");
	if (REF_MARGIN < 1 || REF_MARGIN >= REFI_CYC)
		$error("REF_MARGIN out of range");
	if (WR_DATA_CYC + RP_CYC + (1 << WRP_W) >= (1 << CNT_W))
		$error("WR_DATA_CYC too large");

	// --------------------------------------------------------------
	// Device-wide timers
	// --------------------------------------------------------------
	localparam int T_CCD = 0;
	localparam int T_WTR = 1;
	localparam int T_XSNR = 2;
	localparam int T_XSRD = 3;
	localparam int T_XP = 4;
	localparam int T_XARD = 5;
	localparam int T_CKE = 6;
	localparam int T_RFC = 7;
	localparam int T_ODT = 8;
	localparam int T_AXPD = 9;
	localparam int NT = 10;

	logic [CNT_W-1:0] tmr_q [NT];
	logic [CNT_W-1:0] tmr_val [NT];
	logic [NT-1:0] tmr_ld;
	logic [CNT_W-1:0] act_tmr_q [NUM_BANKS];
	logic [CNT_W-1:0] pre_tmr_q [NUM_BANKS];
	logic [FAW_CYC-2:0] faw_hist_q;
	logic [REFI_W-1:0] refi_q;
	dctg_pwr_t pwr_q;
	dctg_pwr_t pwr_d;
	dctg_cmd_t cmd_q;
	logic [BANK_W-1:0] bank_q;
	logic [ADDR_W-1:0] addr_q;
	logic odt_q;

	// Zero flags per timer
	wire [NT-1:0] clr;
	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++)
		begin : g_tmr
			assign clr[gi] = (tmr_q[gi] == '0);
			// Load one short, as the issuing cycle counts; then count down to zero
			always_ff @(posedge link.sys_clk)
			begin
				if (srst)
					tmr_q[gi] <= '0;
				else if (tmr_ld[gi])
					tmr_q[gi] <= tmr_val[gi] - 1'b1;
				else if (!clr[gi])
					tmr_q[gi] <= tmr_q[gi] - 1'b1;
			end
		end
	endgenerate

	// --------------------------------------------------------------
	// Command selection
	// --------------------------------------------------------------
	wire awake = (pwr_q == DCTG_AWAKE);
	wire nr_ok = clr[T_XSNR] & clr[T_XP];
	wire [BANK_W-1:0] bsel = req_bank;
	wire faw_ok = ($countones(faw_hist_q) < FAW_ACTS);
	wire bank_act_ok = (act_tmr_q[bsel] == '0);
	wire bank_pre_ok = (pre_tmr_q[bsel] == '0);
	wire ref_ok = awake & nr_ok & clr[T_RFC];
	wire cke_ok = clr[T_CKE];
	wire odt_settled = clr[T_ODT] & (odt_req == odt_q);
	wire urgent = (refi_q <= REFI_W'(REF_MARGIN));
	logic cmd_ok;
	always_comb
	begin
		cmd_ok = 1'b0;
		unique case (req_cmd)
			DCTG_NOP: cmd_ok = 1'b1;
			DCTG_ACT: cmd_ok = awake & nr_ok & clr[T_RFC] & faw_ok & bank_act_ok;
			DCTG_RD: cmd_ok = awake & clr[T_CCD] & clr[T_WTR] & clr[T_XSRD] & clr[T_XARD];
			DCTG_WR: cmd_ok = awake & nr_ok & clr[T_CCD];
			DCTG_PRE: cmd_ok = awake & nr_ok & bank_pre_ok;
			DCTG_REF: cmd_ok = ref_ok;
			DCTG_MRS, DCTG_OCD: cmd_ok = awake & nr_ok;
			DCTG_PDE, DCTG_SRE: cmd_ok = awake & nr_ok & cke_ok & odt_settled;
			DCTG_PDX: cmd_ok = (pwr_q == DCTG_PDOWN) & cke_ok;
			DCTG_SRX: cmd_ok = (pwr_q == DCTG_SELF) & cke_ok;
			default: cmd_ok = 1'b0;
		endcase
	end

	// Urgent refresh steals the slot; column and activate requests wait
	wire is_col = (req_cmd == DCTG_RD) | (req_cmd == DCTG_WR) | (req_cmd == DCTG_ACT);
	wire ref_now = urgent & ref_ok;
	wire blocked = urgent & is_col;
	assign req_ready = req_valid & cmd_ok & ~ref_now & ~blocked;
	wire issue = req_ready & (req_cmd != DCTG_NOP);
	dctg_cmd_t cmd_d;
	assign cmd_d = ref_now ? DCTG_REF : (issue ? req_cmd : DCTG_NOP);
	wire do_act = (cmd_d == DCTG_ACT);
	wire do_rd = (cmd_d == DCTG_RD);
	wire do_wr = (cmd_d == DCTG_WR);
	wire cke_edge = (cmd_d == DCTG_PDE) | (cmd_d == DCTG_SRE) |
		(cmd_d == DCTG_PDX) | (cmd_d == DCTG_SRX);
	wire odt_change = (odt_req != odt_q) & clr[T_AXPD];

	// Slow active exit is seven minus additive latency, never under one
	wire [CNT_W-1:0] al_w = CNT_W'(additive_latency);
	wire [CNT_W-1:0] xards = (al_w >= CNT_W'(XARDS_BASE_CYC)) ? CNT_W'(1) :
		CNT_W'(XARDS_BASE_CYC) - al_w;
	wire [CNT_W-1:0] xard_sel = slow_exit ? xards : CNT_W'(XARD_CYC);
	wire [CNT_W-1:0] dal = CNT_W'(WR_DATA_CYC) + CNT_W'(wr_recovery) +
		CNT_W'(RP_CYC);

	// Timer loads per command
	always_comb
	begin
		tmr_ld = '0;
		for (int i = 0; i < NT; i++)
			tmr_val[i] = '0;
		tmr_ld[T_CCD] = do_rd | do_wr;
		tmr_val[T_CCD] = CNT_W'(CCD_CYC);
		tmr_ld[T_WTR] = do_wr;
		tmr_val[T_WTR] = CNT_W'(WR_DATA_CYC + WTR_CYC);
		tmr_ld[T_XSNR] = (cmd_d == DCTG_SRX);
		tmr_val[T_XSNR] = CNT_W'(XSNR_CYC);
		tmr_ld[T_XSRD] = (cmd_d == DCTG_SRX);
		tmr_val[T_XSRD] = CNT_W'(XSRD_CYC);
		tmr_ld[T_XP] = (cmd_d == DCTG_PDX);
		tmr_val[T_XP] = CNT_W'(XP_CYC);
		tmr_ld[T_XARD] = (cmd_d == DCTG_PDX);
		tmr_val[T_XARD] = xard_sel;
		tmr_ld[T_CKE] = cke_edge;
		tmr_val[T_CKE] = CNT_W'(CKE_CYC);
		tmr_ld[T_RFC] = (cmd_d == DCTG_REF);
		tmr_val[T_RFC] = CNT_W'(RFC_CYC);
		tmr_ld[T_ODT] = odt_change;
		tmr_val[T_ODT] = CNT_W'(ANPD_CYC);
		tmr_ld[T_AXPD] = (cmd_d == DCTG_PDX) | (cmd_d == DCTG_SRX);
		tmr_val[T_AXPD] = CNT_W'(AXPD_CYC);
	end

	// --------------------------------------------------------------
	// Per-bank timers
	// --------------------------------------------------------------
	generate
		for (gi = 0; gi < NUM_BANKS; gi++)
		begin : g_bank
			wire hit = (req_bank == BANK_W'(gi)) & issue;
			always_ff @(posedge link.sys_clk)
			begin
				if (srst)
				begin
					act_tmr_q[gi] <= '0;
					pre_tmr_q[gi] <= '0;
				end
				else
				begin
					if (hit & do_wr & req_autopre)
						act_tmr_q[gi] <= dal - 1'b1;
					else if (act_tmr_q[gi] != '0)
						act_tmr_q[gi] <= act_tmr_q[gi] - 1'b1;
					if (hit & do_rd)
						pre_tmr_q[gi] <= CNT_W'(RTP_CYC) + al_w - 1'b1;
					else if (pre_tmr_q[gi] != '0)
						pre_tmr_q[gi] <= pre_tmr_q[gi] - 1'b1;
				end
			end
		end
	endgenerate

	// --------------------------------------------------------------
	// Power state machine
	// --------------------------------------------------------------
	always_comb
	begin
		pwr_d = pwr_q;
		unique case (pwr_q)
			DCTG_AWAKE:
			begin
				if (cmd_d == DCTG_PDE)
					pwr_d = DCTG_PDOWN;
				else if (cmd_d == DCTG_SRE)
					pwr_d = DCTG_SELF;
			end
			DCTG_PDOWN:
				if (cmd_d == DCTG_PDX)
					pwr_d = DCTG_AWAKE;
			DCTG_SELF:
				if (cmd_d == DCTG_SRX)
					pwr_d = DCTG_AWAKE;
			default: pwr_d = DCTG_AWAKE;
		endcase
	end

	// --------------------------------------------------------------
	// Link registers, activate history and refresh debt
	// --------------------------------------------------------------
	always_ff @(posedge link.sys_clk)
	begin
		if (srst)
		begin
			pwr_q <= DCTG_AWAKE;
			cmd_q <= DCTG_NOP;
			bank_q <= '0;
			addr_q <= '0;
			odt_q <= 1'b0;
			faw_hist_q <= '0;
			refi_q <= REFI_W'(REFI_CYC);
		end
		else
		begin
			pwr_q <= pwr_d;
			cmd_q <= cmd_d;
			bank_q <= req_bank;
			addr_q <= req_addr;
			if (odt_change)
				odt_q <= odt_req;
			faw_hist_q <= {faw_hist_q[FAW_CYC-3:0], do_act};
			if (cmd_d == DCTG_REF || pwr_q == DCTG_SELF)
				refi_q <= REFI_W'(REFI_CYC);
			else if (refi_q != '0)
				refi_q <= refi_q - 1'b1;
		end
	end

	assign link.cmd = cmd_q;
	assign link.bank = bank_q;
	assign link.addr = addr_q;
	assign link.cke = (pwr_q == DCTG_AWAKE);
	assign link.odt = odt_q;
	assign refresh_urgent = urgent;
	assign pwr_state = pwr_q;
	// Clock may stop once enable has been low over a full cycle
	assign clk_stop_ok = ~awake & (tmr_q[T_CKE] < CNT_W'(CKE_CYC - 1));
endmodule // dctg_ctrl_end
`default_nettype wire

// ### logic/dctg_pkg.sv
// Timing constants, command codes and mode fields for the DDR2 command timing guard
`default_nettype none
package dctg_pkg;
	// --------------------------------------------------------------
	// Clock and printed times (picoseconds)
	// --------------------------------------------------------------
	localparam int CLK_PS = 8000;
	localparam int FAW_PS = 50000;
	localparam int WR_PS = 15000;
	localparam int RP_PS = 15000;
	localparam int WTR_PS = 7500;
	localparam int RTP_PS = 7500;
	localparam int RFC_PS = 127500;
	localparam int XSNR_EXTRA_PS = 10000;
	localparam int REFI_PS = 7800000;
	localparam int MOD_MAX_PS = 12000;
	localparam int OIT_MAX_PS = 12000;

	// Least times round up, longest times round down, never below one cycle
	function automatic int ru(input int ps);
		ru = (ps + CLK_PS - 1) / CLK_PS;
		if (ru < 1)
			ru = 1;
	endfunction
	function automatic int rd(input int ps);
		rd = ps / CLK_PS;
		if (rd < 1)
			rd = 1;
	endfunction

	// --------------------------------------------------------------
	// Cycle counts
	// --------------------------------------------------------------
	localparam int FAW_CYC = ru(FAW_PS);
	localparam int FAW_ACTS = 4;
	localparam int CCD_CYC = 2;
	localparam int WR_CYC = ru(WR_PS);
	localparam int RP_CYC = ru(RP_PS);
	localparam int WTR_MIN_CYC = 2;
	localparam int WTR_CYC = (ru(WTR_PS) < WTR_MIN_CYC) ? WTR_MIN_CYC : ru(WTR_PS);
	localparam int RTP_CYC = ru(RTP_PS);
	localparam int RFC_CYC = ru(RFC_PS);
	localparam int XSNR_CYC = ru(RFC_PS + XSNR_EXTRA_PS);
	localparam int XSRD_CYC = 200;
	localparam int XP_CYC = 2;
	localparam int XARD_CYC = 2;
	localparam int XARDS_BASE_CYC = 7;
	localparam int CKE_CYC = 3;
	localparam int REFI_CYC = rd(REFI_PS);
	localparam int MOD_CYC = rd(MOD_MAX_PS);
	localparam int OIT_CYC = rd(OIT_MAX_PS);
	localparam int AOND_CYC = 2;
	localparam int AOFD_CYC = 2;
	localparam int ANPD_CYC = 3;
	localparam int AXPD_CYC = 8;

	// --------------------------------------------------------------
	// Widths and mode-register fields
	// --------------------------------------------------------------
	localparam int CNT_W = 8;
	localparam int REFI_W = 10;
	localparam int ADDR_W = 13;
	localparam int BANK_W = 3;
	localparam int MR_SLOW_EXIT_BIT = 12;
	localparam int MR_TERM_LO_BIT = 2;
	localparam int MR_TERM_HI_BIT = 6;
	localparam int AL_W = 3;
	localparam int WRP_W = 3;

	typedef enum logic [3:0] {
		DCTG_NOP = 4'h0,
		DCTG_ACT = 4'h1,
		DCTG_RD = 4'h2,
		DCTG_WR = 4'h3,
		DCTG_PRE = 4'h4,
		DCTG_REF = 4'h5,
		DCTG_MRS = 4'h6,
		DCTG_OCD = 4'h7,
		DCTG_PDE = 4'h8,
		DCTG_PDX = 4'h9,
		DCTG_SRE = 4'ha,
		DCTG_SRX = 4'hb
	} dctg_cmd_t;

	// Power state, Gray coded along awake -> down -> self-refresh
	typedef enum logic [1:0] {
		DCTG_AWAKE = 2'b00,
		DCTG_PDOWN = 2'b01,
		DCTG_SELF = 2'b11
	} dctg_pwr_t;
endpackage
`default_nettype wire

// ### logic/dctg_link_if.sv
// Command link between the controller end and the DRAM end
`timescale 1ns/100ps
`default_nettype none
interface dctg_link_if
	import dctg_pkg::*;
(
	input wire logic sys_clk
);
	dctg_cmd_t cmd;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic cke;
	logic odt;

	modport ctrl (input sys_clk, output cmd, output bank, output addr, output cke, output odt);
	modport dram (input sys_clk, input cmd, input bank, input addr, input cke, input odt);
endinterface
`default_nettype wire

// ### logic/dctg_dram_end.sv
// DRAM end: termination latencies, mode capture and calibration test drive
`timescale 1ns/100ps
`default_nettype none
module dctg_dram_end
	import dctg_pkg::*;
(
	input wire logic srst,
	dctg_link_if.dram link,
	output logic term_active,
	output logic [1:0] term_setting,
	output logic slow_exit,
	output logic ocd_drive
);
	// --------------------------------------------------------------
	// Termination control pipeline
	// --------------------------------------------------------------
	logic [AOND_CYC-1:0] odt_pipe_q;
	logic term_pos_q;
	logic term_neg_q;
	logic [1:0] term_q;
	logic slow_q;
	logic [CNT_W-1:0] ocd_cnt_q;
	logic [CNT_W-1:0] mod_cnt_q;
	logic [1:0] term_pend_q;
	wire is_mrs = (link.cmd == DCTG_MRS);
	wire is_ocd = (link.cmd == DCTG_OCD);
	wire [1:0] term_new = {link.addr[MR_TERM_HI_BIT], link.addr[MR_TERM_LO_BIT]};

	// Sampled level reaches the rising-edge stage after exactly two edges
	always_ff @(posedge link.sys_clk)
	begin
		if (srst)
		begin
			odt_pipe_q <= '0;
			term_pos_q <= 1'b0;
		end
		else
		begin
			odt_pipe_q <= {odt_pipe_q[AOND_CYC-2:0], link.odt};
			term_pos_q <= odt_pipe_q[AOND_CYC-1];
		end
	end

	// Falling-edge copy holds termination on for the extra half cycle
	always_ff @(negedge link.sys_clk)
	begin
		if (srst)
			term_neg_q <= 1'b0;
		else
			term_neg_q <= term_pos_q;
	end

	// On at the rising edge, off at the following falling edge
	assign term_active = term_pos_q | term_neg_q;

	// --------------------------------------------------------------
	// Mode capture and calibration test drive
	// --------------------------------------------------------------
	always_ff @(posedge link.sys_clk)
	begin
		if (srst)
		begin
			term_q <= 2'h0;
			term_pend_q <= 2'h0;
			mod_cnt_q <= '0;
			slow_q <= 1'b0;
			ocd_cnt_q <= '0;
			ocd_drive <= 1'b0;
		end
		else
		begin
			if (is_mrs)
			begin
				term_pend_q <= term_new;
				mod_cnt_q <= CNT_W'(MOD_CYC);
				slow_q <= link.addr[MR_SLOW_EXIT_BIT];
			end
			else if (mod_cnt_q != '0)
				mod_cnt_q <= mod_cnt_q - 1'b1;
			if (mod_cnt_q == CNT_W'(1))
				term_q <= term_pend_q;
			if (is_ocd)
				ocd_cnt_q <= CNT_W'(OIT_CYC);
			else if (ocd_cnt_q != '0)
				ocd_cnt_q <= ocd_cnt_q - 1'b1;
			if (ocd_cnt_q == CNT_W'(1))
				ocd_drive <= 1'b1;
			else if (link.cmd != DCTG_NOP && !is_ocd)
				ocd_drive <= 1'b0;
		end
	end

	assign term_setting = term_q;
	assign slow_exit = slow_q;
endmodule // dctg_dram_end
`default_nettype wire

// ### testbench/dctg_link_sva.sv
// Link command spacing assertions for the DDR2 command timing guard
`timescale 1ns/100ps
`default_nettype none
module dctg_link_sva
	import dctg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire dctg_cmd_t cmd,
	input wire logic [BANK_W-1:0] bank,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic cke,
	input wire logic odt
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic [5:0] act_q;
	logic [7:0] srx_q;
	wire is_act = cmd == DCTG_ACT;
	wire is_col = cmd == DCTG_RD || cmd == DCTG_WR;
	wire quiet_ref = cmd != DCTG_ACT && cmd != DCTG_REF;
	// --------------------------------------------------------------
	// Activate history and age since self-refresh exit
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		act_q <= srst ? 6'h00 : {act_q[4:0], is_act};
		srx_q <= srst ? 8'hff : (cmd == DCTG_SRX) ? 8'h00 : srx_q + {7'h00, srx_q != 8'hff};
	end
	// Fifteen cycles free of activate and refresh
	sequence s_rfc;
		quiet_ref [*8] ##1 quiet_ref [*7];
	endsequence
	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	a_faw_count: assert property ($countones({act_q, is_act}) <= FAW_ACTS)
		else $error("more than four activates in seven cycles");
	a_col_gap: assert property (is_col |=> !is_col)
		else $error("column commands too close");
	a_wtr_gap: assert property (cmd == DCTG_WR |=> (cmd != DCTG_RD) [*5])
		else $error("read too soon after write");
	a_rfc_gap: assert property (cmd == DCTG_REF |=> s_rfc)
		else $error("activate or refresh too soon after refresh");
	a_cke_width: assert property ($changed(cke) |=> $stable(cke) [*2])
		else $error("clock enable pulse too short");
	a_srx_read: assert property (cmd == DCTG_RD |-> srx_q >= 8'hc7)
		else $error("read too soon after self-refresh exit");
	a_srx_other: assert property (!(cmd inside {DCTG_NOP, DCTG_RD}) |-> srx_q >= 8'h11)
		else $error("command too soon after self-refresh exit");
	a_pdx_next: assert property (cmd == DCTG_PDX |=> cmd inside {DCTG_NOP, DCTG_RD})
		else $error("non-read command right after power-down exit");
	a_odt_settled: assert property (cmd inside {DCTG_PDE, DCTG_SRE} |->
		$past(odt, 1) == $past(odt, 2) && $past(odt, 2) == $past(odt, 3))
		else $error("termination level moved before power-down");
	a_odt_exit: assert property (cmd inside {DCTG_PDX, DCTG_SRX} |=> $stable(odt) [*6])
		else $error("termination changed right after exit");
endmodule // dctg_link_sva
`default_nettype wire

// ### testbench/ddr2_command_timing_guard_tb_top.sv
// Top testbench for the DDR2 command timing guard
`timescale 1ns/100ps
`default_nettype none
module ddr2_command_timing_guard_tb_top
	import dctg_pkg::*;
;
	localparam int WR_DATA = 4;
	logic sys_clk, srst, req_valid, req_autopre, req_ready, odt_req;
	logic refresh_urgent, clk_stop_ok, term_active, slow_exit, ocd_drive, urg_seen;
	logic [1:0] term_setting;
	dctg_cmd_t req_cmd;
	dctg_pwr_t pwr_state;
	logic [BANK_W-1:0] req_bank;
	logic [ADDR_W-1:0] req_addr;
	logic [WRP_W-1:0] wr_recovery;
	logic [AL_W-1:0] additive_latency;
	int errors = 0, total_checks = 0, cyc = 0, t0, t1;
	int ts [5];
	dctg_link_if dctg_link_if_inst (.sys_clk(sys_clk));
	dctg_ctrl_end #(.REF_MARGIN(8)) dctg_ctrl_end_inst (.srst, .link(dctg_link_if_inst),
		.req_valid, .req_cmd, .req_bank, .req_addr, .req_autopre, .req_ready, .odt_req,
		.wr_recovery, .additive_latency, .slow_exit, .refresh_urgent, .clk_stop_ok, .pwr_state);
	dctg_dram_end dctg_dram_end_inst (.srst, .link(dctg_link_if_inst), .term_active,
		.term_setting, .slow_exit, .ocd_drive);
	dctg_link_sva dctg_link_sva_inst (.sys_clk, .srst, .cmd(dctg_link_if_inst.cmd),
		.bank(dctg_link_if_inst.bank), .addr(dctg_link_if_inst.addr),
		.cke(dctg_link_if_inst.cke), .odt(dctg_link_if_inst.odt));
	// --------------------------------------------------------------
	// Clock, cycle count and watchdog
	// --------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		cyc <= cyc + 1;
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		errors++;
		final_report();
	end
	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Request a command, return the cycle it is taken in or -1
	task automatic issue(input dctg_cmd_t c, input int b, input int a, input logic ap,
		input int lim, output int t);
		t = -1;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_cmd = c;
		req_bank = b[BANK_W-1:0];
		req_addr = a[ADDR_W-1:0];
		req_autopre = ap;
		for (int n = 0; n < lim && t < 0; n++)
		begin
			#1;
			if (req_ready === 1'b1)
			begin
				t = cyc;
				@(posedge sys_clk);
			end
			else
				@(negedge sys_clk);
		end
		if (t < 0)
			req_valid = 1'b0;
	endtask
	task automatic idle(input int n);
		@(negedge sys_clk);
		req_valid = 1'b0;
		repeat (n) @(negedge sys_clk);
	endtask
	// Two commands back to back in one bank, checked spacing
	task automatic gap(input dctg_cmd_t a, input dctg_cmd_t b, input int bk, input int exp);
		issue(a, bk, 0, 1'b0, 300, t0);
		issue(b, bk, 0, 1'b0, 300, t1);
		check(t1 - t0, exp);
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial
	begin
		srst = 1'b1;
		req_valid = 1'b0;
		req_cmd = DCTG_NOP;
		req_bank = 3'h0;
		req_addr = 13'h0000;
		req_autopre = 1'b0;
		odt_req = 1'b0;
		wr_recovery = 3'h2;
		additive_latency = 3'h2;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		srst = 1'b0;
		issue(DCTG_PDX, 0, 0, 1'b0, 4, t0);
		check(t0, -1);
		gap(DCTG_RD, DCTG_RD, 0, CCD_CYC);
		gap(DCTG_WR, DCTG_RD, 0, WR_DATA + WTR_CYC);
		for (int i = 0; i < 5; i++)
			issue(DCTG_ACT, i, 0, 1'b0, 20, ts[i]);
		check(ts[4] - ts[0], FAW_CYC);
		issue(DCTG_WR, 1, 0, 1'b1, 20, t0);
		issue(DCTG_ACT, 1, 0, 1'b0, 40, t1);
		check(t1 - t0, WR_DATA + 2 + RP_CYC);
		gap(DCTG_RD, DCTG_PRE, 2, RTP_CYC + 2);
		gap(DCTG_REF, DCTG_ACT, 0, RFC_CYC);
		idle(4);
		// Termination on then off, latency seen at the DRAM end
		for (int v = 1; v >= 0; v--)
		begin
			@(negedge sys_clk);
			odt_req = v[0];
			while (dctg_link_if_inst.odt !== v[0])
				@(negedge sys_clk);
			repeat (2) @(negedge sys_clk);
			#1;
			check(term_active, !v[0]);
			@(posedge sys_clk);
			#1;
			check(term_active, 1'b1);
			@(negedge sys_clk);
			#1;
			check(term_active, v[0]);
		end
		issue(DCTG_MRS, 0, 'h1040, 1'b0, 20, t0);
		idle(2);
		check(term_setting, 2'h2);
		check(slow_exit, 1'b1);
		issue(DCTG_OCD, 0, 0, 1'b0, 20, t0);
		idle(2);
		check(ocd_drive, 1'b1);
		// Slow then fast active power-down exit
		for (int m = 1; m >= 0; m--)
		begin
			issue(DCTG_MRS, 0, m * 'h1000, 1'b0, 20, t0);
			idle(4);
			issue(DCTG_PDE, 0, 0, 1'b0, 20, t0);
			idle(3);
			check(pwr_state, DCTG_PDOWN);
			check(clk_stop_ok, 1'b1);
			gap(DCTG_PDX, DCTG_RD, 0, m ? XARDS_BASE_CYC - 2 : XARD_CYC);
			idle(10);
		end
		issue(DCTG_SRE, 0, 0, 1'b0, 20, t0);
		idle(3);
		check(pwr_state, DCTG_SELF);
		gap(DCTG_SRX, DCTG_ACT, 0, XSNR_CYC);
		issue(DCTG_RD, 0, 0, 1'b0, 300, t1);
		check(t1 - t0, XSRD_CYC);
		idle(1);
		// Refresh must come on its own before the interval runs out
		t1 = -1;
		urg_seen = 1'b0;
		for (int n = 0; n < 1200 && t1 < 0; n++)
		begin
			@(negedge sys_clk);
			if (refresh_urgent === 1'b1)
				urg_seen = 1'b1;
			if (dctg_link_if_inst.cmd === DCTG_REF)
				t1 = cyc;
		end
		check(t1 >= 0 && t1 - t0 <= REFI_CYC, 1'b1);
		check(urg_seen, 1'b1);
		final_report();
	end
endmodule // ddr2_command_timing_guard_tb_top
`default_nettype wire
